// [core/sieacc_top.sv]
`timescale 1ns/1ps
`include "sieacc_cfg.svh"
//
// Contract
// [R1] Entry-sleep enable bits 5:0, one per input, gate entry-sleep faults.
// [R2] Control bit 4 enables runtime CRC fault interrupt; resets to zero.
// [R3] Control bit 2 enables thermal shutdown fault interrupt.
// [R4] Control bit 1 enables sync pin short fault interrupt.
// [R5] Control bit 0 enables packet check mismatch interrupt.
// [R6] Test bit 3 enables corrected single-bit OTP load error interrupt.
// [R7] Test bit 1 enables self-test complete interrupt; resets to zero.
// [R8] Test bit 0 enables self-test fail interrupt; stays writable.
// [R9] Monitor enable bits 5:0 switch each input's monitoring on or off.
// [R10] Scaling bit zero selects 1x: 0.2 V base, 5 mV steps.
// [R11] Scaling bit one selects 4x: 0.8 V base, 20 mV steps.
// [R12] Input 1 fast undervoltage limit is 8-bit code scaled by range.
// [R13] Input 1 fast undervoltage limit resets to zero, lowest threshold.
// [R14] Fault drives interrupt low only when enabled; masking leaves detection alone.
// [R15] Reserved bits take writes harmlessly and never affect masking or monitoring.
module sieacc_top #(
  parameter logic [6:0] DEV_ADDR = `SIEACC_I2C_ADDR
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Bus pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Fault events
  input  wire logic [5:0]  entrySleepFault,
  input  wire logic        runtimeCrcFault,
  input  wire logic        thermalFault,
  input  wire logic        syncPinFault,
  input  wire logic        packetCheckFault,
  input  wire logic        otpCorrectedFault,
  input  wire logic        selftestDoneFault,
  input  wire logic        selftestFailFault,
  // Interrupt
  output logic             interruptOutN,
  // Channel configuration
  output logic [5:0]       channelMonitorEnable,
  output logic [5:0]       channelRangeScaling,
  output logic [7:0]       ch1FastUvLimit,
  output logic [12:0]      ch1FastUvThresholdMv
);
  import sieacc_pkg::*;

  sieacc_top_state_type s;
  sieacc_top_state_type next_s;
  sieacc_cfg_if         cfg ();

  logic sclHigh;
  logic sdaBit;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] rdNow;

  // Unmapped offsets read as zero
  function automatic logic [7:0] readReg(input logic [7:0] addr,
                                         input sieacc_top_state_type r);
    case (addr)
      `SIEACC_OFS_ENTRY_SLEEP_EN: readReg = r.entrySleepEn;
      `SIEACC_OFS_CONTROL_EN:     readReg = r.ctrlEn;
      `SIEACC_OFS_TEST_EN:        readReg = r.testEn;
      `SIEACC_OFS_MONITOR_EN:     readReg = r.monEn;
      `SIEACC_OFS_RANGE_SCALE:    readReg = r.rangeScale;
      `SIEACC_OFS_CH1_UV_LIMIT:   readReg = r.uvLimit;
      default:                    readReg = `SIEACC_RD_UNMAPPED;
    endcase
  endfunction

  // Edges use the second and third stages only
  assign sclHigh   = s.sclSync[1];
  assign sdaBit    = s.sdaSync[1];
  assign sclRise   = s.sclSync[1] & ~s.sclSync[2];
  assign sclFall   = ~s.sclSync[1] & s.sclSync[2];
  assign startSeen = sclHigh & s.sclSync[2] & ~s.sdaSync[1] & s.sdaSync[2];
  assign stopSeen  = sclHigh & s.sclSync[2] & s.sdaSync[1] & ~s.sdaSync[2];
  // Byte at the pointer, loaded when a read byte starts
  assign rdNow     = readReg(s.ptr, s);

  always_comb begin
    next_s = s;
    next_s.sclSync = {s.sclSync[1:0], sclIn};
    next_s.sdaSync = {s.sdaSync[1:0], sdaIn};
    next_s.sdaOut  = 1'b0;
    if (startSeen) begin
      next_s.st     = I2C_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.sdaOe  = 1'b0;
    end else if (stopSeen) begin
      next_s.st    = I2C_IDLE;
      next_s.sdaOe = 1'b0;
    end else begin
      case (s.st)
        I2C_IDLE: begin
          next_s.sdaOe = 1'b0;
        end
        I2C_ADDR: begin
          if (sclRise) begin
            next_s.shift  = {s.shift[6:0], sdaBit};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == 4'h8) begin
            // Foreign address: stay off the bus until next start
            if (s.shift[7:1] == DEV_ADDR) begin
              next_s.rnw   = s.shift[0];
              next_s.sdaOe = 1'b1;
              next_s.st    = I2C_ADDR_ACK;
            end else begin
              next_s.st = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (sclFall) begin
            next_s.bitCnt = 4'h0;
            if (s.rnw) begin
              next_s.shift  = rdNow;
              next_s.sdaOe  = ~rdNow[7];
              next_s.bitCnt = 4'h1;
              next_s.ptr    = s.ptr + 8'h01;
              next_s.st     = I2C_RDATA;
            end else begin
              next_s.sdaOe = 1'b0;
              next_s.st    = I2C_PTR;
            end
          end
        end
        I2C_PTR: begin
          if (sclRise) begin
            next_s.shift  = {s.shift[6:0], sdaBit};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == 4'h8) begin
            next_s.ptr   = s.shift;
            next_s.sdaOe = 1'b1;
            next_s.st    = I2C_PTR_ACK;
          end
        end
        I2C_PTR_ACK: begin
          if (sclFall) begin
            next_s.sdaOe  = 1'b0;
            next_s.bitCnt = 4'h0;
            next_s.st     = I2C_WDATA;
          end
        end
        I2C_WDATA: begin
          if (sclRise) begin
            next_s.shift  = {s.shift[6:0], sdaBit};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == 4'h8) begin
            // Reserved bits stored for readback only
            case (s.ptr)
              `SIEACC_OFS_ENTRY_SLEEP_EN: next_s.entrySleepEn = s.shift; // [R1] [R15]
              `SIEACC_OFS_CONTROL_EN:     next_s.ctrlEn = s.shift;       // [R2] [R3] [R4] [R5]
              `SIEACC_OFS_TEST_EN:        next_s.testEn = s.shift;       // [R6] [R7] [R8]
              `SIEACC_OFS_MONITOR_EN:     next_s.monEn = s.shift;        // [R9] [R15]
              `SIEACC_OFS_RANGE_SCALE:    next_s.rangeScale = s.shift;   // [R10] [R11]
              `SIEACC_OFS_CH1_UV_LIMIT:   next_s.uvLimit = s.shift;      // [R12]
              default:                    next_s.uvLimit = s.uvLimit;
            endcase
            // Auto-increment lets one transaction fill the whole bank
            next_s.ptr   = s.ptr + 8'h01;
            next_s.sdaOe = 1'b1;
            next_s.st    = I2C_WDATA_ACK;
          end
        end
        I2C_WDATA_ACK: begin
          if (sclFall) begin
            next_s.sdaOe  = 1'b0;
            next_s.bitCnt = 4'h0;
            next_s.st     = I2C_WDATA;
          end
        end
        I2C_RDATA: begin
          if (sclFall) begin
            if (s.bitCnt == 4'h8) begin
              next_s.sdaOe = 1'b0;
              next_s.st    = I2C_RDATA_ACK;
            end else begin
              next_s.sdaOe  = ~s.shift[6];
              next_s.shift  = {s.shift[6:0], 1'b0};
              next_s.bitCnt = s.bitCnt + 4'h1;
            end
          end
        end
        I2C_RDATA_ACK: begin
          if (sclRise) begin
            next_s.masterNack = sdaBit;
          end else if (sclFall) begin
            if (s.masterNack) begin
              next_s.st = I2C_IDLE;
            end else begin
              next_s.shift  = rdNow;
              next_s.sdaOe  = ~rdNow[7];
              next_s.bitCnt = 4'h1;
              next_s.ptr    = s.ptr + 8'h01;
              next_s.st     = I2C_RDATA;
            end
          end
        end
        default: begin
          next_s.st    = I2C_IDLE;
          next_s.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s.st           <= I2C_IDLE;
      s.sclSync      <= 3'h7;
      s.sdaSync      <= 3'h7;
      s.bitCnt       <= 4'h0;
      s.shift        <= 8'h00;
      s.ptr          <= 8'h00;
      s.rnw          <= 1'b0;
      s.masterNack   <= 1'b0;
      s.sdaOe        <= 1'b0;
      s.sdaOut       <= 1'b0;
      s.entrySleepEn <= `SIEACC_RST_ENABLE;
      s.ctrlEn       <= `SIEACC_RST_ENABLE;  // [R2]
      s.testEn       <= `SIEACC_RST_ENABLE;  // [R7]
      s.monEn        <= `SIEACC_RST_ENABLE;
      s.rangeScale   <= `SIEACC_RST_ENABLE;
      s.uvLimit      <= `SIEACC_RST_UV_LIMIT; // [R13]
    end else begin
      s <= next_s;
    end
  end

  // Fault inputs are same-clock logic and are not synchronised
  assign cfg.entrySleepEn    = s.entrySleepEn[`SIEACC_CH_MSB:0];
  assign cfg.ctrlEn          = s.ctrlEn;
  assign cfg.testEn          = s.testEn;
  assign cfg.entrySleepFault = entrySleepFault;
  assign cfg.ctrlFault       = {3'h0, runtimeCrcFault, 1'b0, thermalFault,
                                syncPinFault, packetCheckFault};
  assign cfg.testFault       = {4'h0, otpCorrectedFault, 1'b0,
                                selftestDoneFault, selftestFailFault};
  assign cfg.rangeX4         = s.rangeScale[0];
  assign cfg.code            = s.uvLimit;

  sieacc_irq_gate u_irq (
    .clk  (clk),
    .rstn (rstn),
    .cfg  (cfg.irq)
  );

  sieacc_scale_calc u_scale (
    .clk  (clk),
    .rstn (rstn),
    .cfg  (cfg.scale)
  );

  assign sdaOut               = s.sdaOut;
  assign sdaOe                = s.sdaOe;
  assign interruptOutN        = cfg.irqN;
  assign channelMonitorEnable = s.monEn[`SIEACC_CH_MSB:0];      // [R9]
  assign channelRangeScaling  = s.rangeScale[`SIEACC_CH_MSB:0]; // [R10] [R11]
  assign ch1FastUvLimit       = s.uvLimit;
  assign ch1FastUvThresholdMv = cfg.mv;
endmodule

// [core/sieacc_cfg.svh]
`ifndef SIEACC_CFG_SVH
`define SIEACC_CFG_SVH

// Register offsets
`define SIEACC_OFS_ENTRY_SLEEP_EN 8'h1a
`define SIEACC_OFS_CONTROL_EN     8'h1b
`define SIEACC_OFS_TEST_EN        8'h1c
`define SIEACC_OFS_MONITOR_EN     8'h1e
`define SIEACC_OFS_RANGE_SCALE    8'h1f
`define SIEACC_OFS_CH1_UV_LIMIT   8'h20

// Reset values and unmapped read value
`define SIEACC_RST_ENABLE         8'h00
`define SIEACC_RST_UV_LIMIT       8'h00
`define SIEACC_RD_UNMAPPED        8'h00

// Field positions
`define SIEACC_BIT_RUNTIME_CRC    4
`define SIEACC_BIT_THERMAL        2
`define SIEACC_BIT_SYNC_PIN       1
`define SIEACC_BIT_PACKET_CHECK   0
`define SIEACC_BIT_OTP_CORRECTED  3
`define SIEACC_BIT_SELFTEST_DONE  1
`define SIEACC_BIT_SELFTEST_FAIL  0
`define SIEACC_CH_MSB             5

// Defined fields; reserved positions never reach the interrupt
`define SIEACC_MASK_CHANNELS      8'h3f
`define SIEACC_MASK_CONTROL       8'h17
`define SIEACC_MASK_TEST          8'h0b

// Threshold scaling in millivolts
`define SIEACC_X1_BASE_MV         13'h00c8
`define SIEACC_X1_STEP_MV         13'h0005
`define SIEACC_X4_BASE_MV         13'h0320
`define SIEACC_X4_STEP_MV         13'h0014

// Bus target address, arbitrary value
`define SIEACC_I2C_ADDR           7'h30

`endif

// [core/sieacc_pkg.sv]
package sieacc_pkg;

  typedef enum logic [3:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_PTR,
    I2C_PTR_ACK,
    I2C_WDATA,
    I2C_WDATA_ACK,
    I2C_RDATA,
    I2C_RDATA_ACK
  } sieacc_i2c_state_type;

  typedef struct packed {
    sieacc_i2c_state_type st;
    logic [2:0]           sclSync;
    logic [2:0]           sdaSync;
    logic [3:0]           bitCnt;
    logic [7:0]           shift;
    logic [7:0]           ptr;
    logic                 rnw;
    logic                 masterNack;
    logic                 sdaOe;
    logic                 sdaOut;
    logic [7:0]           entrySleepEn;
    logic [7:0]           ctrlEn;
    logic [7:0]           testEn;
    logic [7:0]           monEn;
    logic [7:0]           rangeScale;
    logic [7:0]           uvLimit;
  } sieacc_top_state_type;

  typedef struct packed {
    logic irqN;
  } sieacc_irq_state_type;

  typedef struct packed {
    logic [12:0] mv;
  } sieacc_scale_state_type;

endpackage

// [core/sieacc_cfg_if.sv]
`timescale 1ns/1ps
interface sieacc_cfg_if;
  logic [5:0]  entrySleepEn;
  logic [7:0]  ctrlEn;
  logic [7:0]  testEn;
  logic [5:0]  entrySleepFault;
  logic [7:0]  ctrlFault;
  logic [7:0]  testFault;
  logic        irqN;
  logic        rangeX4;
  logic [7:0]  code;
  logic [12:0] mv;

  modport top (
    output entrySleepEn, ctrlEn, testEn, entrySleepFault, ctrlFault, testFault,
    output rangeX4, code,
    input  irqN, mv
  );
  modport irq (
    input  entrySleepEn, ctrlEn, testEn, entrySleepFault, ctrlFault, testFault,
    output irqN
  );
  modport scale (
    input  rangeX4, code,
    output mv
  );
endinterface

// [core/sieacc_irq_gate.sv]
`timescale 1ns/1ps
`include "sieacc_cfg.svh"
module sieacc_irq_gate (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rstn,
  // Enables and faults
  sieacc_cfg_if.irq cfg
);
  import sieacc_pkg::*;

  sieacc_irq_state_type s;
  sieacc_irq_state_type next_s;

  // Masking only gates the pin; detection upstream is untouched
  always_comb begin
    next_s = s;
    next_s.irqN = ~(|(cfg.entrySleepFault & cfg.entrySleepEn)              // [R1] [R14]
                 | |(cfg.ctrlFault & cfg.ctrlEn & `SIEACC_MASK_CONTROL)    // [R2] [R3] [R4] [R5] [R15]
                 | |(cfg.testFault & cfg.testEn & `SIEACC_MASK_TEST));     // [R6] [R7] [R8] [R15]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s.irqN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cfg.irqN = s.irqN;
endmodule

// [core/sieacc_scale_calc.sv]
`timescale 1ns/1ps
`include "sieacc_cfg.svh"
module sieacc_scale_calc (
  // Clock and reset
  input wire logic    clk,
  input wire logic    rstn,
  // Code and range in, millivolts out
  sieacc_cfg_if.scale cfg
);
  import sieacc_pkg::*;

  sieacc_scale_state_type s;
  sieacc_scale_state_type next_s;

  function automatic logic [12:0] codeToMv(input logic x4, input logic [7:0] code);
    logic [12:0] wide;
    wide = {5'h00, code};
    if (x4) begin
      codeToMv = `SIEACC_X4_BASE_MV + wide * `SIEACC_X4_STEP_MV; // [R11] [R12]
    end else begin
      codeToMv = `SIEACC_X1_BASE_MV + wide * `SIEACC_X1_STEP_MV; // [R10] [R12]
    end
  endfunction

  always_comb begin
    next_s = s;
    next_s.mv = codeToMv(cfg.rangeX4, cfg.code);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s.mv <= `SIEACC_X1_BASE_MV;
    end else begin
      s <= next_s;
    end
  end

  assign cfg.mv = s.mv;
endmodule

// [sim/sieacc_checker.sv]
`timescale 1ns/1ps
module sieacc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Bus pins
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  // Faults and interrupt
  input wire logic [5:0]  entrySleepFault,
  input wire logic        runtimeCrcFault,
  input wire logic        thermalFault,
  input wire logic        syncPinFault,
  input wire logic        packetCheckFault,
  input wire logic        otpCorrectedFault,
  input wire logic        selftestDoneFault,
  input wire logic        selftestFailFault,
  input wire logic        interruptOutN,
  // Configuration
  input wire logic [5:0]  channelMonitorEnable,
  input wire logic [5:0]  channelRangeScaling,
  input wire logic [7:0]  ch1FastUvLimit,
  input wire logic [12:0] ch1FastUvThresholdMv
);
  logic anyFault;
  assign anyFault = |{entrySleepFault, runtimeCrcFault, thermalFault, syncPinFault,
                      packetCheckFault, otpCorrectedFault, selftestDoneFault, selftestFailFault};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rel;
    $rose(rstn);
  endsequence
  // Updates land while the clock line is low, so a high stretch is quiet
  sequence s_idle;
    sclIn [*4];
  endsequence
  property p_thr_x1;
    !channelRangeScaling[0] |=>
      ch1FastUvThresholdMv == 13'h00c8 + 13'h0005 * $past(ch1FastUvLimit);
  endproperty
  property p_thr_x4;
    channelRangeScaling[0] |=>
      ch1FastUvThresholdMv == 13'h0320 + 13'h0014 * $past(ch1FastUvLimit);
  endproperty
  property p_rst_limit;
    s_rel |-> ch1FastUvLimit == 8'h00 && ch1FastUvThresholdMv == 13'h00c8;
  endproperty
  property p_rst_mon;
    s_rel |-> channelMonitorEnable == 6'h00 && channelRangeScaling == 6'h00;
  endproperty
  property p_rst_irq;
    s_rel |-> interruptOutN [*8];
  endproperty
  property p_irq_quiet;
    !anyFault |=> interruptOutN;
  endproperty
  property p_irq_cause;
    $fell(interruptOutN) |-> $past(anyFault);
  endproperty
  property p_cfg_hold;
    s_idle |-> $stable(channelMonitorEnable) && $stable(channelRangeScaling)
               && $stable(ch1FastUvLimit);
  endproperty
  a_thr_x1: assert property (p_thr_x1) else $error("threshold wrong at 1x");
  a_thr_x4: assert property (p_thr_x4) else $error("threshold wrong at 4x");
  a_rst_limit: assert property (p_rst_limit) else $error("limit not cleared");
  a_rst_mon: assert property (p_rst_mon) else $error("channel config not cleared");
  a_rst_irq: assert property (p_rst_irq) else $error("interrupt after reset");
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without fault");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt fell unprompted");
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while idle");
endmodule

bind sieacc_top sieacc_checker chk (.clk, .rstn, .sclIn, .sdaIn, .sdaOut, .sdaOe,
  .entrySleepFault, .runtimeCrcFault, .thermalFault, .syncPinFault, .packetCheckFault,
  .otpCorrectedFault, .selftestDoneFault, .selftestFailFault, .interruptOutN,
  .channelMonitorEnable, .channelRangeScaling, .ch1FastUvLimit, .ch1FastUvThresholdMv);

// [sim/sieacc_host.sv]
`timescale 1ns/1ps
module sieacc_host (
  // Clock
  input  wire logic clk,
  // Bus pins
  output logic      scl,
  output logic      sdaM,
  input  wire logic sdaWire
);
  initial begin
    scl = 1'h1;
    sdaM = 1'h1;
  end
  // Five clocks a phase keeps above the four-clock minimum
  task automatic ph();
    repeat (5) @(negedge clk);
  endtask
  task automatic bitx(input logic b, output logic s);
    ph();
    sdaM = b;
    ph();
    scl = 1'h1;
    ph();
    s = sdaWire;
    ph();
    scl = 1'h0;
  endtask
  task automatic start();
    ph();
    sdaM = 1'h1;
    ph();
    scl = 1'h1;
    ph();
    sdaM = 1'h0;
    ph();
    scl = 1'h0;
  endtask
  // Last bit released: acknowledge sampled, or a read ended by no-ack
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(1'h1, a);
  endtask
  task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic isRd,
                        input logic [7:0] wd, output logic [7:0] rd, output logic ak);
    logic a;
    start();
    xbyte({dev, 1'h0}, rd, ak);
    xbyte(ptr, rd, a);
    if (isRd) begin
      start();
      xbyte({dev, 1'h1}, rd, a);
      xbyte(8'hff, rd, a);
    end else
      xbyte(wd, rd, a);
    ph();
    sdaM = 1'h0;
    ph();
    scl = 1'h1;
    ph();
    sdaM = 1'h1;
    ph();
  endtask
endmodule

// [sim/sieacc_tb_top.sv]
`timescale 1ns/1ps
module sieacc_tb_top;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [12:0] flt;
  logic        sdaOe, sdaOut, irqN, scl, sdaM, ak;
  logic [5:0]  monEn, rng;
  logic [7:0]  lim, rd;
  logic [7:0]  mdl [7];
  logic [7:0]  offs [7];
  logic [12:0] mv;
  int          seed = 11748;
  int          n_errors = 0;
  int          n_tests = 0;
  // Pull-up wins unless the device or the host pulls low
  wire sda = (sdaOe ? sdaOut : 1'h1) & sdaM;
  always #5 clk = ~clk;
  sieacc_top uut (.clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .entrySleepFault(flt[5:0]), .runtimeCrcFault(flt[6]),
    .thermalFault(flt[7]), .syncPinFault(flt[8]), .packetCheckFault(flt[9]),
    .otpCorrectedFault(flt[10]), .selftestDoneFault(flt[11]), .selftestFailFault(flt[12]),
    .interruptOutN(irqN), .channelMonitorEnable(monEn), .channelRangeScaling(rng),
    .ch1FastUvLimit(lim), .ch1FastUvThresholdMv(mv));
  sieacc_host host (.clk(clk), .scl(scl), .sdaM(sdaM), .sdaWire(sda));
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic expIrq(input logic [12:0] f);
    logic [7:0] c;
    logic [7:0] t;
    c = {3'h0, f[6], 1'h0, f[7], f[8], f[9]};
    t = {4'h0, f[10], 1'h0, f[11], f[12]};
    return !(|(f[5:0] & mdl[0][5:0]) || |(c & mdl[1]) || |(t & mdl[2]));
  endfunction
  function automatic logic [12:0] expMv();
    return mdl[4][0] ? 13'h0320 + 13'h0014 * mdl[5] : 13'h00c8 + 13'h0005 * mdl[5];
  endfunction
  task automatic doReset();
    rstn = 1'h0;
    mdl = '{default: 8'h00};
    repeat (6) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    host.access(7'h30, offs[i], 1'h0, d, rd, ak);
    chk("address ack", 13'h0000, ak);
    if (i < 6)
      mdl[i] = d;
  endtask
  task automatic checkAll();
    for (int i = 0; i < 7; i++) begin
      host.access(7'h30, offs[i], 1'h1, 8'h00, rd, ak);
      chk("readback", mdl[i], rd);
    end
    chk("monitor enable", mdl[3][5:0], monEn);
    chk("range scaling", mdl[4][5:0], rng);
    chk("uv limit", mdl[5], lim);
    chk("uv threshold", expMv(), mv);
    // One-hot walk first, then random mixes
    for (int j = 0; j < 22; j++) begin
      flt = j < 13 ? 13'h0001 << j : 13'($random(seed));
      repeat (2) @(negedge clk);
      chk("interrupt", expIrq(flt), irqN);
    end
  endtask
  initial begin
    offs = '{8'h1a, 8'h1b, 8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h1d};
    flt = 13'h0000;
    doReset();
    // Foreign address: no ack, and the readback below shows no write
    host.access(7'h31, offs[0], 1'h0, 8'h55, rd, ak);
    chk("foreign ack", 13'h0001, ak);
    checkAll();
    for (int i = 0; i < 6; i++)
      wr(i, 8'hff);
    checkAll();
    wr(4, 8'h00);
    wr(6, 8'h5a);
    checkAll();
    // Reserved bits alone must enable nothing
    wr(0, 8'hc0);
    wr(1, 8'he8);
    wr(2, 8'hf4);
    checkAll();
    for (int n = 0; n < 4; n++) begin
      wr({$random(seed)} % 6, 8'($random(seed)));
      wr({$random(seed)} % 6, 8'($random(seed)));
      checkAll();
    end
    doReset();
    checkAll();
    conclude();
  end
  initial begin
    repeat (90000) @(negedge clk);
    n_errors++;
    conclude();
  end
endmodule
